// [hdl/cfd_pkg.sv]
// Constants, field layouts and encodings for the control-flow word decoder.
package cfd_pkg;
  localparam int        ADDR_W         = 6;
  localparam int        DATA_W         = 32;
  // Register byte offsets.
  localparam logic [5:0] OFS_ALU_WORD  = 6'h00;
  localparam logic [5:0] OFS_EXP_WORD  = 6'h04;
  localparam logic [5:0] OFS_VIEW_WORD = 6'h08;
  localparam logic [5:0] OFS_LOOP      = 6'h0C;
  localparam logic [5:0] OFS_SRC       = 6'h10;
  localparam logic [5:0] OFS_DST       = 6'h14;
  localparam logic [5:0] OFS_CMP       = 6'h18;
  localparam logic [5:0] OFS_CTRL      = 6'h1C;
  localparam logic [5:0] OFS_INDEX     = 6'h20;
  localparam logic [5:0] OFS_STATUS    = 6'h24;
  localparam logic [5:0] OFS_RESULT    = 6'h28;
  localparam logic [5:0] OFS_EXP_ADDR  = 6'h2C;
  localparam logic [5:0] OFS_LOCK      = 6'h30;
  localparam logic [31:0] RST_WORD     = 32'h0000_0000;
  // Field positions of the extended ALU high word.
  localparam int LMODE_LO = 0;
  localparam int ADDR2_LO = 2;
  localparam int ADDR3_LO = 10;
  localparam int OPC_LO   = 26;
  localparam int BARR_BIT = 31;
  // Field positions of the export low word.
  localparam int BASE_LO  = 0;
  localparam int TYPE_LO  = 13;
  localparam int SREG_LO  = 15;
  localparam int REL_BIT  = 22;
  localparam int IREG_LO  = 23;
  localparam int ESZ_LO   = 30;
  // Field positions of the unordered-view word.
  localparam int VID_LO   = 0;
  localparam int VOP_LO   = 4;
  // Control register bits.
  localparam int CTL_MEM  = 0;
  localparam int CTL_CLS  = 1;
  localparam int CTL_WQM  = 3;
  localparam int CTL_VPM  = 4;
  localparam int CTL_PS   = 5;
  // Clause opcodes.
  localparam logic [3:0] OPC_ALU      = 4'h8;
  localparam logic [3:0] OPC_PUSH_B   = 4'h9;
  localparam logic [3:0] OPC_POP_A    = 4'hA;
  localparam logic [3:0] OPC_POP2_A   = 4'hB;
  localparam logic [3:0] OPC_EXT      = 4'hC;
  localparam logic [3:0] OPC_CONT     = 4'hD;
  localparam logic [3:0] OPC_BREAK    = 4'hE;
  localparam logic [3:0] OPC_ELSE_A   = 4'hF;
  // Lock modes.
  localparam logic [1:0] LOCK_NONE    = 2'h0;
  localparam logic [1:0] LOCK_LOOP    = 2'h3;
  // Transfer classes held in the control register.
  localparam logic [1:0] CLS_SCRATCH  = 2'h0;
  localparam logic [1:0] CLS_STREAM   = 2'h1;
  localparam logic [1:0] CLS_EXPORT   = 2'h2;
  // Export index limits.
  localparam logic [12:0] PIX_MAX     = 13'h0007;
  localparam logic [12:0] DEPTH_IDX   = 13'h003D;
  localparam logic [12:0] PARAM_MAX   = 13'h001F;
  localparam logic [12:0] POS_MIN     = 13'h003C;
  localparam logic [12:0] POS_MAX     = 13'h003F;
  localparam logic [12:0] STREAM_MAX  = 13'h1FFF;
  localparam logic [1:0]  ESZ_BAD     = 2'h3;
  // View operations.
  localparam logic [5:0] VOP_NOP      = 6'h00;
  localparam logic [5:0] VOP_TYPED    = 6'h01;
  localparam logic [5:0] VOP_CMPX     = 6'h04;
  localparam logic [5:0] VOP_ADD      = 6'h07;
  localparam logic [5:0] VOP_SUB      = 6'h08;
  localparam logic [5:0] VOP_RSUB     = 6'h09;
  localparam logic [5:0] VOP_MIN_S    = 6'h0A;
  localparam logic [5:0] VOP_MIN_U    = 6'h0B;
  localparam logic [5:0] VOP_MAX_S    = 6'h0C;
  localparam logic [5:0] VOP_MAX_U    = 6'h0D;
  localparam logic [5:0] VOP_AND      = 6'h0E;
  localparam logic [5:0] VOP_OR       = 6'h0F;
  localparam logic [5:0] VOP_XOR      = 6'h10;
  localparam logic [5:0] VOP_INC      = 6'h12;
  localparam logic [5:0] VOP_DEC      = 6'h13;
  localparam logic [5:0] VOP_ST_DW    = 6'h14;
  localparam logic [5:0] VOP_ST_SH    = 6'h15;
  localparam logic [5:0] VOP_ST_BY    = 6'h16;
  localparam logic [5:0] VOP_NOP_R    = 6'h20;
  localparam logic [5:0] VOP_XCHG_R   = 6'h22;
  localparam logic [5:0] VOP_CMPX_R   = 6'h24;
  localparam logic [5:0] VOP_RTN_BASE = 6'h20;
  typedef enum logic [1:0] {
    CFD_IDLE  = 2'b00,
    CFD_WAIT  = 2'b01,
    CFD_ISSUE = 2'b11
  } cfd_state_t;
endpackage : cfd_pkg

// [hdl/cfd_decoder.sv]
// Decoder for extended ALU, export and unordered-view control-flow words.
//
// Decided for this implementation: the strobed register port and the placing of the registers.
`timescale 1ns/10ps
module cfd_decoder (
  // Clock and reset
  input  wire logic                      clk_i,
  input  wire logic                      rst_i,
  // Register port
  input  wire logic [cfd_pkg::ADDR_W-1:0] addr_i,
  input  wire logic [cfd_pkg::DATA_W-1:0] wdata_i,
  input  wire logic                      wr_i,
  input  wire logic                      rd_i,
  output logic      [cfd_pkg::DATA_W-1:0] rdata_o,
  // Execution status from the sequencer, asynchronous
  input  wire logic                      prior_idle_i,
  input  wire logic                      mem_commit_i,
  // Clause control
  output logic                           clause_issue_o,
  output logic                           push_before_o,
  output logic [1:0]                     pop_after_o,
  output logic                           else_after_o,
  output logic                           pred_cont_o,
  output logic                           pred_break_o,
  output logic                           pred_stack_upd_o,
  // Fourth lock set and the line address of the third
  output logic                           lock3_en0_o,
  output logic                           lock3_en1_o,
  output logic [7:0]                     lock3_line0_o,
  output logic [7:0]                     lock3_line1_o,
  output logic [7:0]                     lock_line_addr_set2_o,
  // Export and memory decode
  output logic [15:0]                    exp_addr_o,
  output logic [6:0]                     source_reg_num_o,
  output logic [2:0]                     elem_dwords_o,
  output logic                           write_ack_o,
  // View operation
  output logic [3:0]                     view_ident_o,
  output logic [31:0]                    view_result_o,
  output logic                           view_write_o,
  output logic                           view_return_o
);
  import cfd_pkg::*;

  //////////////////////////////////////////////////////////////////////////
  // Software-visible registers, synchronisers and sequencing state.
  logic [31:0] alu_word_reg, exp_word_reg, view_word_reg, loop_reg;
  logic [31:0] src_reg, dst_reg, cmp_reg, index_reg;
  logic [5:0]  ctrl_reg;
  logic        idle_m_reg, idle_s_reg, com_m_reg, com_s_reg, com_d_reg;
  logic        ack_pend_reg, view_pend_reg;
  cfd_state_t  state_reg, state_next;

  wire wr_alu  = wr_i && (addr_i == OFS_ALU_WORD);
  wire wr_exp  = wr_i && (addr_i == OFS_EXP_WORD);
  wire wr_view = wr_i && (addr_i == OFS_VIEW_WORD);

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      alu_word_reg  <= RST_WORD;
      exp_word_reg  <= RST_WORD;
      view_word_reg <= RST_WORD;
      loop_reg      <= RST_WORD;
      src_reg       <= RST_WORD;
      dst_reg       <= RST_WORD;
      cmp_reg       <= RST_WORD;
      index_reg     <= RST_WORD;
      ctrl_reg      <= 6'h00;
    end else if (wr_i) begin
      case (addr_i)
        OFS_ALU_WORD:  alu_word_reg  <= wdata_i;
        OFS_EXP_WORD:  exp_word_reg  <= wdata_i;
        OFS_VIEW_WORD: view_word_reg <= wdata_i;
        OFS_LOOP:      loop_reg      <= wdata_i;
        OFS_SRC:       src_reg       <= wdata_i;
        OFS_DST:       dst_reg       <= wdata_i;
        OFS_CMP:       cmp_reg       <= wdata_i;
        OFS_INDEX:     index_reg     <= wdata_i;
        OFS_CTRL:      ctrl_reg      <= wdata_i[5:0];
        default:       ;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Extended ALU high word.
  wire [1:0] lock_mode_set3      = alu_word_reg[LMODE_LO +: 2];
  wire [7:0] lock_line_addr_set2 = alu_word_reg[ADDR2_LO +: 8];
  wire [7:0] lock_line_addr_set3 = alu_word_reg[ADDR3_LO +: 8];
  wire [3:0] clause_opcode       = alu_word_reg[OPC_LO +: 4];
  wire       barrier             = alu_word_reg[BARR_BIT];
  wire       alu_clause_extended_op = (clause_opcode == OPC_EXT);
  // Reserved bits and reserved opcodes are not checked; they decode as no action.
  wire [7:0] loop_line  = loop_reg[11:4]; // loop index divided by 16
  wire [7:0] lock_base  = (lock_mode_set3 == LOCK_LOOP) ?
                          8'(lock_line_addr_set3 + loop_line) : lock_line_addr_set3;
  wire       lock_en0   = (lock_mode_set3 != LOCK_NONE);
  wire       lock_en1   = lock_mode_set3[1];
  // Whole-pixel and valid-pixel modes conflict, or are set outside pixel shaders.
  wire       mode_bad   = (ctrl_reg[CTL_WQM] && ctrl_reg[CTL_VPM]) ||
                          ((ctrl_reg[CTL_WQM] || ctrl_reg[CTL_VPM]) && !ctrl_reg[CTL_PS]);

  //////////////////////////////////////////////////////////////////////////
  // Issue sequencing: a barrier word holds until the synchronised idle level.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      idle_m_reg <= 1'b0;
      idle_s_reg <= 1'b0;
      com_m_reg  <= 1'b0;
      com_s_reg  <= 1'b0;
      com_d_reg  <= 1'b0;
      view_pend_reg <= 1'b0;
    end else begin
      idle_m_reg <= prior_idle_i;
      idle_s_reg <= idle_m_reg;
      com_m_reg  <= mem_commit_i;
      com_s_reg  <= com_m_reg;
      com_d_reg  <= com_s_reg;
      view_pend_reg <= wr_view;
    end
  end

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      CFD_IDLE:  if (wr_alu) state_next = CFD_WAIT;
      CFD_WAIT:  if (!barrier || idle_s_reg) state_next = CFD_ISSUE;
      CFD_ISSUE: state_next = wr_alu ? CFD_WAIT : CFD_IDLE;
      default:   state_next = CFD_IDLE;
    endcase
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_reg <= CFD_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Export low word.
  wire [12:0] base           = exp_word_reg[BASE_LO +: 13];
  wire [1:0]  xfer_type      = exp_word_reg[TYPE_LO +: 2];
  wire [6:0]  source_reg_num = exp_word_reg[SREG_LO +: 7];
  wire        source_reg_relative = exp_word_reg[REL_BIT];
  wire [6:0]  index_reg_num  = exp_word_reg[IREG_LO +: 7];
  wire [1:0]  elem_size      = exp_word_reg[ESZ_LO +: 2];
  wire        is_mem         = ctrl_reg[CTL_MEM];
  wire [1:0]  xfer_class     = ctrl_reg[CTL_CLS +: 2];
  // Memory types 1 and 3 use the index register; export types ignore size.
  wire        use_index      = is_mem && xfer_type[0];
  wire        ack_req        = is_mem && xfer_type[1];
  wire [6:0]  src_eff        = source_reg_relative ?
                               7'(source_reg_num + loop_reg[6:0]) : source_reg_num;
  wire [1:0]  esz_shift      = (!is_mem || elem_size == ESZ_BAD) ? 2'h0 :
                               elem_size;
  wire [2:0]  elem_dwords    = 3'(3'h1 << esz_shift);
  wire        esz_bad        = is_mem && (elem_size == ESZ_BAD);
  // Only the first element of the index register is used, unswizzled.
  wire [15:0] idx_scaled     = use_index ? 16'(index_reg[15:0] << esz_shift) : 16'h0000;
  wire [15:0] loop_scaled    = 16'(loop_reg[15:0] << esz_shift);
  logic [15:0] base_addr;
  logic        base_ok;

  always_comb begin
    base_addr = {3'h0, base};
    base_ok   = 1'b1;
    case (xfer_class)
      CLS_SCRATCH: begin
        base_addr = {1'b0, base, 2'h0};
        base_ok   = ({1'b0, base, 2'h0} <= 16'h7FFC);
      end
      CLS_STREAM: base_ok = (base <= STREAM_MAX);
      CLS_EXPORT: begin
        case (xfer_type)
          2'h0:    base_ok = (base <= PIX_MAX) || (base == DEPTH_IDX);
          2'h1:    base_ok = (base >= POS_MIN) && (base <= POS_MAX);
          2'h2:    base_ok = (base <= PARAM_MAX);
          default: base_ok = 1'b0;
        endcase
      end
      default: base_ok = 1'b0;
    endcase
  end

  wire [15:0] exp_addr = 16'(base_addr + idx_scaled);

  // Acknowledge request: a new request in the commit cycle keeps the flag set.
  wire commit_rise = com_s_reg && !com_d_reg;
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ack_pend_reg <= 1'b0;
    end else if (wr_exp && is_mem && wdata_i[TYPE_LO + 1]) begin
      ack_pend_reg <= 1'b1;
    end else if (commit_rise) begin
      ack_pend_reg <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Unordered-view operation.
  wire [3:0] view_ident     = view_word_reg[VID_LO +: 4];
  wire [5:0] view_operation = view_word_reg[VOP_LO +: 6];
  wire       lt_s = $signed(src_reg) < $signed(dst_reg);
  wire       lt_u = src_reg < dst_reg;
  logic [31:0] vres;
  logic        vwr;
  logic        vrtn;
  logic        vbad;

  always_comb begin
    vres = dst_reg;
    vwr  = 1'b1;
    vrtn = 1'b0;
    vbad = 1'b0;
    case (view_operation)
      VOP_NOP:   vwr = 1'b0;
      VOP_TYPED, VOP_ST_DW, VOP_ST_SH, VOP_ST_BY: vres = src_reg;
      VOP_CMPX, VOP_CMPX_R: vres = (cmp_reg == dst_reg) ? src_reg : dst_reg;
      VOP_ADD:   vres = 32'(src_reg + dst_reg);
      VOP_SUB:   vres = 32'(dst_reg - src_reg);
      VOP_RSUB:  vres = 32'(src_reg - dst_reg);
      VOP_MIN_S: vres = lt_s ? src_reg : dst_reg;
      VOP_MIN_U: vres = lt_u ? src_reg : dst_reg;
      VOP_MAX_S: vres = (!lt_s && src_reg != dst_reg) ? src_reg : dst_reg;
      VOP_MAX_U: vres = (src_reg > dst_reg) ? src_reg : dst_reg;
      VOP_AND:   vres = dst_reg & src_reg;
      VOP_OR:    vres = dst_reg | src_reg;
      VOP_XOR:   vres = dst_reg ^ src_reg;
      VOP_INC:   vres = (dst_reg >= src_reg) ? 32'h0000_0000 : 32'(dst_reg + 32'h1);
      VOP_DEC:   vres = (dst_reg == 32'h0 || dst_reg > src_reg) ? src_reg :
                        32'(dst_reg - 32'h1);
      VOP_NOP_R: vwr = 1'b0;
      VOP_XCHG_R: vres = src_reg;
      default: begin
        vwr  = 1'b0;
        vbad = 1'b1;
      end
    endcase
    // Returning forms live at 32 and up; they raise view_return_o beside the computed result.
    if (view_operation >= VOP_RTN_BASE && !vbad) begin
      vrtn = 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Registered outputs.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      clause_issue_o        <= 1'b0;
      push_before_o         <= 1'b0;
      pop_after_o           <= 2'h0;
      else_after_o          <= 1'b0;
      pred_cont_o           <= 1'b0;
      pred_break_o          <= 1'b0;
      pred_stack_upd_o      <= 1'b0;
      lock3_en0_o           <= 1'b0;
      lock3_en1_o           <= 1'b0;
      lock3_line0_o         <= 8'h00;
      lock3_line1_o         <= 8'h00;
      lock_line_addr_set2_o <= 8'h00;
      exp_addr_o            <= 16'h0000;
      source_reg_num_o      <= 7'h00;
      elem_dwords_o         <= 3'h1;
      write_ack_o           <= 1'b0;
      view_ident_o          <= 4'h0;
      view_result_o         <= 32'h0000_0000;
      view_write_o          <= 1'b0;
      view_return_o         <= 1'b0;
    end else begin
      clause_issue_o        <= (state_reg == CFD_ISSUE);
      push_before_o         <= (clause_opcode == OPC_PUSH_B);
      pop_after_o           <= (clause_opcode == OPC_POP2_A) ? 2'h2 :
                               (clause_opcode == OPC_POP_A) ? 2'h1 : 2'h0;
      else_after_o          <= (clause_opcode == OPC_ELSE_A);
      pred_cont_o           <= (clause_opcode == OPC_CONT);
      pred_break_o          <= (clause_opcode == OPC_BREAK);
      // Plain clauses never touch the branch stack from predicates.
      pred_stack_upd_o      <= (clause_opcode == OPC_CONT) ||
                               (clause_opcode == OPC_BREAK);
      lock3_en0_o           <= lock_en0;
      lock3_en1_o           <= lock_en1;
      lock3_line0_o         <= lock_base;
      lock3_line1_o         <= 8'(lock_base + 8'h01);
      lock_line_addr_set2_o <= lock_line_addr_set2;
      exp_addr_o            <= exp_addr;
      source_reg_num_o      <= src_eff;
      elem_dwords_o         <= elem_dwords;
      write_ack_o           <= ack_pend_reg && commit_rise;
      view_ident_o          <= view_ident;
      view_result_o         <= vres;
      // Wait one cycle so the new view word is decoded.
      view_write_o          <= vwr && view_pend_reg;
      view_return_o         <= vrtn && view_pend_reg;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Read port: data in the cycle after the strobe; unmapped reads give zero.
  wire [31:0] status_word = {11'h000, loop_scaled[7:0], index_reg_num, vbad, mode_bad, esz_bad,
                             base_ok, ack_pend_reg, alu_clause_extended_op};
  wire [31:0] lock_word   = {14'h0000, lock_en1, lock_en0, lock_base, lock_line_addr_set2};
  logic [31:0] rsel;

  always_comb begin
    case (addr_i)
      OFS_ALU_WORD:  rsel = alu_word_reg;
      OFS_EXP_WORD:  rsel = exp_word_reg;
      OFS_VIEW_WORD: rsel = view_word_reg;
      OFS_LOOP:      rsel = loop_reg;
      OFS_SRC:       rsel = src_reg;
      OFS_DST:       rsel = dst_reg;
      OFS_CMP:       rsel = cmp_reg;
      OFS_INDEX:     rsel = index_reg;
      OFS_CTRL:      rsel = {26'h0000000, ctrl_reg};
      OFS_STATUS:    rsel = status_word;
      OFS_RESULT:    rsel = vres;
      OFS_EXP_ADDR:  rsel = {16'h0000, exp_addr};
      OFS_LOCK:      rsel = lock_word;
      default:       rsel = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_o <= 32'h0000_0000;
    end else if (rd_i) begin
      rdata_o <= rsel;
    end else begin
      rdata_o <= 32'h0000_0000;
    end
  end
endmodule : cfd_decoder

// [tb/cfd_decoder_chk.sv]
// Port-level assertions for the control-flow word decoder.
`timescale 1ns/10ps
module cfd_decoder_chk
  import cfd_pkg::*;
(
  // Clock, reset, register port and memory commit status
  input wire logic                       clk_i,
  input wire logic                       rst_i,
  input wire logic [cfd_pkg::ADDR_W-1:0] addr_i,
  input wire logic [cfd_pkg::DATA_W-1:0] wdata_i,
  input wire logic                       wr_i,
  input wire logic                       mem_commit_i,
  // Decoded outputs
  input wire logic                       clause_issue_o,
  input wire logic                       push_before_o,
  input wire logic [1:0]                 pop_after_o,
  input wire logic                       lock3_en0_o,
  input wire logic                       lock3_en1_o,
  input wire logic [7:0]                 lock3_line0_o,
  input wire logic [7:0]                 lock3_line1_o,
  input wire logic [7:0]                 lock_line_addr_set2_o,
  input wire logic                       view_write_o,
  input wire logic                       write_ack_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  wire alu_wr = wr_i && addr_i == OFS_ALU_WORD;
  wire view_wr = wr_i && addr_i == OFS_VIEW_WORD;
  ////////////////////////////////////////////////////////////////////////////////
  a_lock_set2_addr: assert property (alu_wr |=> ##1 lock_line_addr_set2_o == $past(wdata_i[9:2], 2))
    else $error("set2 line address wrong");
  a_lock_mode_none: assert property (alu_wr && wdata_i[1:0] == LOCK_NONE |=> ##1 !lock3_en0_o && !lock3_en1_o)
    else $error("lock enabled in no-lock mode");
  a_lock_line_pair: assert property (lock3_en1_o |-> lock3_en0_o && lock3_line1_o == lock3_line0_o + 8'h01)
    else $error("second locked line is not the next line");
  a_push_before: assert property (alu_wr && wdata_i[29:26] == OPC_PUSH_B |=> ##1 push_before_o && pop_after_o == 2'h0)
    else $error("push-before decode wrong");
  a_pop_twice: assert property (alu_wr && wdata_i[29:26] == OPC_POP2_A |=> ##1 pop_after_o == 2'h2 && !push_before_o)
    else $error("double pop decode wrong");
  a_issue_no_barrier: assert property (alu_wr && !wdata_i[31] |-> ##[1:4] clause_issue_o)
    else $error("clause without barrier not issued in time");
  a_view_rsvd_quiet: assert property (view_wr && wdata_i[9:4] == 6'h02 |=> !view_write_o [*2])
    else $error("reserved view operation wrote");
  a_ack_after_commit: assert property (write_ack_o |-> $past(mem_commit_i, 3))
    else $error("acknowledge before commit");
  c_issue: cover property (clause_issue_o);
  c_ack: cover property (write_ack_o);
  c_view_write: cover property (view_write_o);
endmodule : cfd_decoder_chk

bind cfd_decoder cfd_decoder_chk u_chk (.clk_i, .rst_i, .addr_i, .wdata_i, .wr_i, .mem_commit_i,
  .clause_issue_o, .push_before_o, .pop_after_o, .lock3_en0_o, .lock3_en1_o, .lock3_line0_o,
  .lock3_line1_o, .lock_line_addr_set2_o, .view_write_o, .write_ack_o);

// [tb/cfd_seq_model.sv]
// Sequencer stand-in: idle level of earlier work and memory commit level.
`timescale 1ns/10ps
module cfd_seq_model #(
  parameter int BUSY_CYC   = 6,
  parameter int COMMIT_CYC = 5
) (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // Requests seen from the decoder and the bench
  input  wire logic issue_i,
  input  wire logic store_i,
  // Status back to the decoder
  output logic      prior_idle_o,
  output logic      mem_commit_o
);
  int busy_reg;
  int cmt_reg;
  // An issued clause keeps earlier work busy, so a barrier must wait.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      busy_reg <= 0;
      cmt_reg  <= 0;
    end else begin
      busy_reg <= issue_i ? BUSY_CYC : (busy_reg > 0 ? busy_reg - 1 : 0);
      cmt_reg  <= store_i ? COMMIT_CYC + 6 : (cmt_reg > 0 ? cmt_reg - 1 : 0);
    end
  end
  assign prior_idle_o = (busy_reg == 0);
  // Commit is a level held six cycles, long past the synchroniser delay.
  assign mem_commit_o = (cmt_reg > 0) && (cmt_reg <= 6);
endmodule : cfd_seq_model

// [tb/test_cf_alu_ext_and_export_decode.sv]
// Self-checking bench for the control-flow word decoder.
`timescale 1ns/10ps
module test_cf_alu_ext_and_export_decode;
  import cfd_pkg::*;
  logic        clk_i = 1'b0, rst_i = 1'b1, wr_i = 1'b0, rd_i = 1'b0, store_r = 1'b0;
  logic [5:0]  addr_i = 6'h00;
  logic [31:0] wdata_i = 32'h0000_0000, rdata_o, view_result_o;
  logic [15:0] exp_addr_o;
  logic [7:0]  lock3_line0_o, lock3_line1_o, lock_line_addr_set2_o;
  logic [6:0]  source_reg_num_o;
  logic [3:0]  view_ident_o;
  logic [2:0]  elem_dwords_o;
  logic [1:0]  pop_after_o;
  logic        prior_idle_i, mem_commit_i, clause_issue_o, push_before_o, else_after_o;
  logic        pred_cont_o, pred_break_o, pred_stack_upd_o, lock3_en0_o, lock3_en1_o;
  logic        write_ack_o, view_write_o, view_return_o;
  int          bad_count = 0;
  int          tests_run = 0;
  logic [5:0]  vops [20] = '{VOP_NOP, VOP_TYPED, 6'h02, VOP_CMPX, VOP_ADD, VOP_SUB, VOP_RSUB,
    VOP_MIN_S, VOP_MIN_U, VOP_MAX_S, VOP_MAX_U, VOP_AND, VOP_OR, VOP_XOR, VOP_INC, VOP_DEC,
    VOP_ST_DW, VOP_NOP_R, VOP_XCHG_R, VOP_CMPX_R};
  logic [14:0] bw [7] = '{15'h1FFF, 15'h0008, 15'h003D, 15'h203B, 15'h203F, 15'h401F, 15'h4020};
  logic [6:0]  bok = 7'b0110101;

  cfd_decoder dut (.clk_i, .rst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .prior_idle_i,
    .mem_commit_i, .clause_issue_o, .push_before_o, .pop_after_o, .else_after_o, .pred_cont_o,
    .pred_break_o, .pred_stack_upd_o, .lock3_en0_o, .lock3_en1_o, .lock3_line0_o,
    .lock3_line1_o, .lock_line_addr_set2_o, .exp_addr_o, .source_reg_num_o, .elem_dwords_o,
    .write_ack_o, .view_ident_o, .view_result_o, .view_write_o, .view_return_o);
  cfd_seq_model #(.BUSY_CYC(20), .COMMIT_CYC(5)) seq (.clk_i, .rst_i, .issue_i(clause_issue_o),
    .store_i(store_r), .prior_idle_o(prior_idle_i), .mem_commit_o(mem_commit_i));

  always #2.5 clk_i = ~clk_i;
  ////////////////////////////////////////////////////////////////////////////////
  task automatic end_sim;
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : end_sim
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    @(posedge clk_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask : wr
  task automatic rd(input logic [5:0] a, output logic [31:0] d);
    @(posedge clk_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 d = rdata_o;
  endtask : rd
  // Bounded wait for the acknowledge; a timeout fails the run.
  task automatic await_hi;
    for (int i = 0; i < 64; i++) begin
      @(posedge clk_i);
      #1;
      if (write_ack_o === 1'b1) return;
    end
    bad_count++;
    end_sim;
  endtask : await_hi
  function automatic logic [31:0] op_ref(input logic [5:0] op, input logic [31:0] s, dv, c);
    case (op)
      VOP_NOP, 6'h02, VOP_NOP_R: return dv;
      VOP_CMPX, VOP_CMPX_R: return (c == dv) ? s : dv;
      VOP_ADD: return s + dv;
      VOP_SUB: return dv - s;
      VOP_RSUB: return s - dv;
      VOP_MIN_S: return ($signed(s) < $signed(dv)) ? s : dv;
      VOP_MIN_U: return (s < dv) ? s : dv;
      VOP_MAX_S: return ($signed(s) > $signed(dv)) ? s : dv;
      VOP_MAX_U: return (s > dv) ? s : dv;
      VOP_AND: return dv & s;
      VOP_OR: return dv | s;
      VOP_XOR: return dv ^ s;
      VOP_INC: return (dv >= s) ? 32'h0 : dv + 32'h1;
      VOP_DEC: return (dv == 32'h0 || dv > s) ? s : dv - 32'h1;
      default: return s;
    endcase
  endfunction : op_ref
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_alu;
    logic [7:0] l0;
    wr(OFS_LOOP, 32'h0000_0020);
    for (int m = 0; m < 12; m++) begin
      wr(OFS_ALU_WORD, {2'b00, m < 4 ? OPC_EXT : m[3:0] + 4'h4, 8'h00, 8'hFE, 8'h5A, m[1:0]});
      repeat (3) @(posedge clk_i);
      #1 l0 = (m == 3) ? 8'h00 : 8'hFE;
      chk(lock_line_addr_set2_o, 8'h5A);
      if (m < 4) chk({lock3_en1_o, lock3_en0_o}, m == 0 ? 2'h0 : m == 1 ? 2'h1 : 2'h3);
      if (m > 0 && m < 4) chk(lock3_line0_o, l0);
      if (m > 3) chk({pred_stack_upd_o, pred_break_o, pred_cont_o, else_after_o, pop_after_o,
        push_before_o}, m == 5 ? 8'h01 : m == 6 ? 8'h02 : m == 7 ? 8'h04 : m == 9 ? 8'h50 :
        m == 10 ? 8'h60 : m == 11 ? 8'h08 : 8'h00);
    end
  endtask : t_alu
  task automatic t_barrier;
    int run = 0;
    wr(OFS_ALU_WORD, {2'b10, OPC_ALU, 26'h0});
    for (int i = 0; i < 60 && clause_issue_o !== 1'b1; i++) begin
      @(posedge clk_i);
      #1 run = prior_idle_i ? run + 1 : 0;
    end
    chk(run >= 2 && clause_issue_o === 1'b1, 1'b1);
  endtask : t_barrier
  task automatic t_export;
    logic [31:0] d;
    wr(OFS_LOOP, 32'h0000_0003);
    wr(OFS_INDEX, 32'h0000_0005);
    for (int s = 0; s < 4; s++) begin
      wr(OFS_CTRL, 32'h0000_0001);
      wr(OFS_EXP_WORD, {s[1:0], 7'h55, 1'b0, 7'h0A, 2'h1, 13'h0003});
      rd(OFS_STATUS, d);
      if (s < 3) chk(elem_dwords_o, 3'h1 << s);
      chk({d[12:6], d[3], d[0]}, {7'h55, s == 3, 1'b0});
      chk(source_reg_num_o, 7'h0A);
      chk(exp_addr_o, 32'hC + (32'h5 << (s < 3 ? s : 0)));
    end
    wr(OFS_CTRL, 32'h0000_0004);
    wr(OFS_EXP_WORD, {9'h000, 1'b1, 7'h0A, 15'h0000});
    rd(OFS_STATUS, d);
    chk(source_reg_num_o, 7'h0D);
    for (int i = 0; i < 7; i++) begin
      wr(OFS_CTRL, {26'h0, i[2:0], i == 0 ? 3'h3 : 3'h4});
      wr(OFS_EXP_WORD, {17'h0, bw[i]});
      rd(OFS_STATUS, d);
      chk(d[2], bok[i]);
      chk(d[4], i > 0 && i < 4);
    end
  endtask : t_export
  task automatic t_ack;
    wr(OFS_CTRL, 32'h0000_0001);
    wr(OFS_EXP_WORD, 32'h0000_4000);
    store_r <= 1'b1;
    @(posedge clk_i);
    store_r <= 1'b0;
    await_hi;
    chk(mem_commit_i, 1'b1);
  endtask : t_ack
  task automatic t_atom;
    logic [31:0] d, e, dv;
    logic w, r;
    for (int k = 0; k < 2; k++) begin
      dv = k ? 32'h0000_0003 : 32'hFFFF_FFFE;
      wr(OFS_SRC, 32'h0000_0005);
      wr(OFS_CMP, k ? 32'h0 : dv);
      for (int i = 0; i < 20; i++) begin
        wr(OFS_DST, dv);
        wr(OFS_VIEW_WORD, {22'h0, vops[i], 4'h9});
        w = 1'b0;
        r = 1'b0;
        repeat (3) begin
          #1 w = w | view_write_o;
          r = r | view_return_o;
          @(posedge clk_i);
        end
        e = op_ref(vops[i], 32'h5, dv, k ? 32'h0 : dv);
        rd(OFS_RESULT, d);
        chk(view_result_o, e);
        chk(d, e);
        chk({view_ident_o, r}, {4'h9, vops[i] > 6'h1F});
        if (vops[i] < 6'h20) chk(w, vops[i] != 6'h00 && vops[i] != 6'h02);
      end
    end
  endtask : t_atom
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    t_alu;
    t_barrier;
    t_export;
    t_ack;
    t_atom;
    end_sim;
  end
endmodule : test_cf_alu_ext_and_export_decode
